// ### design/adsc_pkg.sv
/*
  Shared constants, field positions, reset values and types of the serial control register bank.
  Assumes a single system clock domain; every user names items as adsc_pkg::name.
*/
package adsc_pkg;

  // Control word framing.
  localparam int unsigned CTRL_WORD_BITS = 16;
  localparam int unsigned SEL_HIGH_BIT   = 10;
  localparam int unsigned SEL_LOW_BIT    = 9;

  // Volume word fields.
  localparam int unsigned LEVEL_COMMIT_BIT = 8;
  localparam int unsigned LEVEL_CODE_MSB   = 7;
  localparam logic [7:0]  LEVEL_CODE_UNITY = 8'hff;
  localparam logic [8:0]  GAIN_UNITY       = 9'h100;

  // Playback control word fields.
  localparam int unsigned SOFT_MUTE_BIT     = 0;
  localparam int unsigned DEEMPH_LOW_BIT    = 1;
  localparam int unsigned DEEMPH_HIGH_BIT   = 2;
  localparam int unsigned FORCE_ZERO_BIT    = 3;
  localparam int unsigned ZERO_DETECT_BIT   = 4;

  // Format control word fields.
  localparam int unsigned I2S_FORMAT_BIT    = 0;
  localparam int unsigned LR_POLARITY_BIT   = 1;
  localparam int unsigned WORD_LENGTH_BIT   = 2;
  localparam int unsigned SHARED_LEVEL_BIT  = 3;
  localparam int unsigned ROUTE_LEFT_MSB    = 4;
  localparam int unsigned ROUTE_RIGHT_MSB   = 6;

  // Reset values of the four words.
  localparam logic [15:0] LEFT_VOLUME_RESET   = 16'h00ff;
  localparam logic [15:0] RIGHT_VOLUME_RESET  = 16'h02ff;
  localparam logic [15:0] PLAYBACK_CTRL_RESET = 16'h0400;
  localparam logic [15:0] FORMAT_CTRL_RESET   = 16'h0690;

  // Timing counts.
  localparam int unsigned INIT_CLOCKS    = 1024;
  localparam int unsigned ZERO_RUN_WIDTH = 17;

  typedef enum logic [1:0] {
    REG_LEFT_VOLUME   = 2'b00,
    REG_RIGHT_VOLUME  = 2'b01,
    REG_PLAYBACK_CTRL = 2'b10,
    REG_FORMAT_CTRL   = 2'b11
  } adsc_reg_sel_t;

  typedef enum logic [1:0] {
    DEEMPH_OFF   = 2'b00,
    DEEMPH_48K   = 2'b01,
    DEEMPH_44K1  = 2'b10,
    DEEMPH_32K   = 2'b11
  } adsc_deemph_t;

  typedef enum logic [1:0] {
    ROUTE_MUTE    = 2'b00,
    ROUTE_RIGHT   = 2'b01,
    ROUTE_LEFT    = 2'b10,
    ROUTE_AVERAGE = 2'b11
  } adsc_route_t;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_INIT = 2'b01,
    ST_RUN  = 2'b10
  } adsc_state_t;

  typedef struct packed {
    logic [4:0]    reserved;
    adsc_reg_sel_t reg_sel;
    logic [8:0]    payload;
  } adsc_ctrl_word_t;

  typedef struct packed {
    logic mode_select;
    logic ext_reset_n;
    logic ctrl_clock;
    logic ctrl_latch;
    logic ctrl_data;
    logic bit_clock;
    logic lr_clock;
    logic audio_data;
  } adsc_pins_t;

endpackage : adsc_pkg

// ### design/adsc_sync.sv
/*
  Two flip-flop synchroniser for a group of pin levels.
  Assumes the inputs are asynchronous levels; only the second stage is visible outside.
*/
`timescale 1ns/1ps
module adsc_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : adsc_sync

// ### design/adsc_ctrl_regs.sv
/*
  Serial control port and control register bank of a stereo audio converter.
  Assumes all pins are asynchronous to CLK and are sampled at the system clock rate,
  which must be well above the rates of the serial control clock and the bit clock.
*/
`timescale 1ns/1ps
module adsc_ctrl_regs #(
  parameter int unsigned ZERO_RUN_BITS = 65536
) (
  input  wire logic                 CLK,
  input  wire logic                 RST,
  input  wire logic                 MODE_SELECT,
  input  wire logic                 EXTERNAL_RESET_PIN_N,
  input  wire logic                 SERIAL_CONTROL_CLOCK,
  input  wire logic                 CONTROL_LATCH,
  input  wire logic                 CONTROL_SERIAL_IN,
  input  wire logic                 SERIAL_BIT_CLOCK,
  input  wire logic                 LEFT_RIGHT_CLOCK,
  input  wire logic                 AUDIO_DATA_IN,
  output logic [8:0]                LEFT_GAIN,
  output logic [8:0]                RIGHT_GAIN,
  output logic                      SOFT_MUTE,
  output adsc_pkg::adsc_deemph_t    DEEMPH_MODE,
  output logic                      OUT_MID_SCALE,
  output logic                      I2S_FORMAT,
  output logic                      WORD_LEN_18,
  output logic                      LR_POLARITY,
  output logic                      CHAN_IS_LEFT,
  output adsc_pkg::adsc_route_t     LEFT_ROUTE,
  output adsc_pkg::adsc_route_t     RIGHT_ROUTE,
  output logic                      CTRL_READY
);

  localparam logic [adsc_pkg::ZERO_RUN_WIDTH-1:0] ZERO_RUN_LIMIT =
    adsc_pkg::ZERO_RUN_WIDTH'(ZERO_RUN_BITS);
  localparam logic [10:0] INIT_LAST = 11'(adsc_pkg::INIT_CLOCKS - 1);

  adsc_pkg::adsc_pins_t       pins_raw;
  adsc_pkg::adsc_pins_t       pins_s;
  adsc_pkg::adsc_state_t      state_q;
  adsc_pkg::adsc_state_t      state_d;
  adsc_pkg::adsc_ctrl_word_t  word_in;
  adsc_pkg::adsc_deemph_t     deemph_reg;
  adsc_pkg::adsc_deemph_t     deemph_pin;
  adsc_pkg::adsc_route_t      left_route_reg;
  adsc_pkg::adsc_route_t      right_route_reg;

  logic [10:0]                         init_cnt_q;
  logic                                ctrl_clock_prev_q;
  logic                                ctrl_latch_prev_q;
  logic                                bit_clock_prev_q;
  logic [adsc_pkg::CTRL_WORD_BITS-1:0] shift_q;
  logic [15:0]                         regs_q [4];
  logic [7:0]                          left_active_q;
  logic [7:0]                          right_active_q;
  logic [adsc_pkg::ZERO_RUN_WIDTH-1:0] zero_run_q;
  logic                                hold;
  logic                                sw_mode;
  logic                                ctrl_clock_rise;
  logic                                latch_fall;
  logic                                bit_clock_rise;
  logic                                write_en;
  logic                                zero_run_hit;
  logic [7:0]                          right_code;
  logic [15:0]                         play_w;
  logic [15:0]                         fmt_w;
  logic                                left_commit;
  logic                                right_commit;
  logic                                pin_mute;

  // Converts a level code into the gain numerator over 256.
  function automatic logic [8:0] level_gain(input logic [7:0] code);
    logic [8:0] gain;
    gain = {1'b0, code};
    if (code == adsc_pkg::LEVEL_CODE_UNITY) begin
      gain = adsc_pkg::GAIN_UNITY;
    end
    return gain;
  endfunction : level_gain

  assign pins_raw.mode_select = MODE_SELECT;
  assign pins_raw.ext_reset_n = EXTERNAL_RESET_PIN_N;
  assign pins_raw.ctrl_clock  = SERIAL_CONTROL_CLOCK;
  assign pins_raw.ctrl_latch  = CONTROL_LATCH;
  assign pins_raw.ctrl_data   = CONTROL_SERIAL_IN;
  assign pins_raw.bit_clock   = SERIAL_BIT_CLOCK;
  assign pins_raw.lr_clock    = LEFT_RIGHT_CLOCK;
  assign pins_raw.audio_data  = AUDIO_DATA_IN;

  // All pins pass the same two stages, so data and shift clock keep their relative timing.
  adsc_sync #(
    .WIDTH($bits(adsc_pkg::adsc_pins_t))
  ) u_pin_sync (
    .clk      (CLK),
    .rst      (RST),
    .async_in (pins_raw),
    .sync_out (pins_s)
  );

  // Internal reset covers the system reset and a low external reset pin.
  assign hold    = RST || !pins_s.ext_reset_n;
  assign sw_mode = pins_s.mode_select;

  assign ctrl_clock_rise = pins_s.ctrl_clock && !ctrl_clock_prev_q;
  assign latch_fall      = !pins_s.ctrl_latch && ctrl_latch_prev_q;
  assign bit_clock_rise  = pins_s.bit_clock && !bit_clock_prev_q;

  assign word_in  = shift_q;
  assign write_en = latch_fall && sw_mode && (state_q == adsc_pkg::ST_RUN);

  assign play_w = regs_q[adsc_pkg::REG_PLAYBACK_CTRL];
  assign fmt_w  = regs_q[adsc_pkg::REG_FORMAT_CTRL];

  assign zero_run_hit = (zero_run_q >= ZERO_RUN_LIMIT);

  // Shared level uses the left active code for the right output.
  assign right_code = fmt_w[adsc_pkg::SHARED_LEVEL_BIT] ? left_active_q : right_active_q;

  // Fields decoded from the stored words.
  assign deemph_reg = adsc_pkg::adsc_deemph_t'(
    {play_w[adsc_pkg::DEEMPH_HIGH_BIT], play_w[adsc_pkg::DEEMPH_LOW_BIT]});
  assign left_route_reg = adsc_pkg::adsc_route_t'(
    {fmt_w[adsc_pkg::ROUTE_LEFT_MSB], fmt_w[adsc_pkg::ROUTE_LEFT_MSB+1]});
  assign right_route_reg = adsc_pkg::adsc_route_t'(
    {fmt_w[adsc_pkg::ROUTE_RIGHT_MSB], fmt_w[adsc_pkg::ROUTE_RIGHT_MSB+1]});

  // Parallel pin mode: a low latch pin mutes; data and shift clock pins pick de-emphasis.
  assign pin_mute   = !pins_s.ctrl_latch;
  assign deemph_pin = adsc_pkg::adsc_deemph_t'({pins_s.ctrl_clock, pins_s.ctrl_data});

  // Commit strobes; a write with the commit bit clear only updates the stored word.
  assign left_commit  = write_en && word_in.payload[adsc_pkg::LEVEL_COMMIT_BIT] &&
                        (word_in.reg_sel == adsc_pkg::REG_LEFT_VOLUME);
  assign right_commit = write_en && word_in.payload[adsc_pkg::LEVEL_COMMIT_BIT] &&
                        (word_in.reg_sel == adsc_pkg::REG_RIGHT_VOLUME);

  // Edge history of the synchronised pins.
  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_clock_prev_q <= 1'b0;
      ctrl_latch_prev_q <= 1'b0;
      bit_clock_prev_q  <= 1'b0;
    end else begin
      ctrl_clock_prev_q <= pins_s.ctrl_clock;
      ctrl_latch_prev_q <= pins_s.ctrl_latch;
      bit_clock_prev_q  <= pins_s.bit_clock;
    end
  end

  // Initialisation sequence after the external reset pin rises.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      adsc_pkg::ST_HOLD: begin
        state_d = adsc_pkg::ST_INIT;
      end
      adsc_pkg::ST_INIT: begin
        if (init_cnt_q == INIT_LAST) begin
          state_d = adsc_pkg::ST_RUN;
        end
      end
      adsc_pkg::ST_RUN: begin
        state_d = adsc_pkg::ST_RUN;
      end
      default: begin
        state_d = adsc_pkg::ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (hold) begin
      state_q    <= adsc_pkg::ST_HOLD;
      init_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_q == adsc_pkg::ST_INIT) begin
        init_cnt_q <= init_cnt_q + 11'h001;
      end
    end
  end

  // Serial shift register, most significant bit first.
  // The word is kept after a latch fall, but a latch fall during initialisation writes nothing, so a word loaded then is lost.
  always_ff @(posedge CLK) begin
    if (hold) begin
      shift_q <= '0;
    end else if (sw_mode && ctrl_clock_rise && pins_s.ctrl_latch) begin
      shift_q <= {shift_q[adsc_pkg::CTRL_WORD_BITS-2:0], pins_s.ctrl_data};
    end
  end

  // Control words, stored as written including the selection bits.
  always_ff @(posedge CLK) begin
    if (hold) begin
      regs_q[adsc_pkg::REG_LEFT_VOLUME]   <= adsc_pkg::LEFT_VOLUME_RESET;
      regs_q[adsc_pkg::REG_RIGHT_VOLUME]  <= adsc_pkg::RIGHT_VOLUME_RESET;
      regs_q[adsc_pkg::REG_PLAYBACK_CTRL] <= adsc_pkg::PLAYBACK_CTRL_RESET;
      regs_q[adsc_pkg::REG_FORMAT_CTRL]   <= adsc_pkg::FORMAT_CTRL_RESET;
    end else if (write_en) begin
      regs_q[word_in.reg_sel] <= shift_q;
    end
  end

  // Active levels follow the stored code only on a commit write.
  always_ff @(posedge CLK) begin
    if (hold) begin
      left_active_q  <= adsc_pkg::LEFT_VOLUME_RESET[adsc_pkg::LEVEL_CODE_MSB:0];
      right_active_q <= adsc_pkg::RIGHT_VOLUME_RESET[adsc_pkg::LEVEL_CODE_MSB:0];
    end else begin
      if (left_commit) begin
        left_active_q <= word_in.payload[adsc_pkg::LEVEL_CODE_MSB:0];
      end
      if (right_commit) begin
        right_active_q <= word_in.payload[adsc_pkg::LEVEL_CODE_MSB:0];
      end
    end
  end

  // Zero run counter on the audio data, counted in bit clock edges.
  always_ff @(posedge CLK) begin
    if (hold) begin
      zero_run_q <= '0;
    end else if (bit_clock_rise) begin
      if (pins_s.audio_data) begin
        zero_run_q <= '0;
      end else if (!zero_run_hit) begin
        zero_run_q <= zero_run_q + 1'b1;
      end
    end
  end

  // Attenuation outputs.
  always_ff @(posedge CLK) begin
    if (hold) begin
      LEFT_GAIN  <= adsc_pkg::GAIN_UNITY;
      RIGHT_GAIN <= adsc_pkg::GAIN_UNITY;
    end else if (sw_mode) begin
      LEFT_GAIN  <= level_gain(left_active_q);
      RIGHT_GAIN <= level_gain(right_code);
    end else begin
      LEFT_GAIN  <= adsc_pkg::GAIN_UNITY;
      RIGHT_GAIN <= adsc_pkg::GAIN_UNITY;
    end
  end

  // Mute and de-emphasis, from the register or from the parallel pins.
  always_ff @(posedge CLK) begin
    if (hold) begin
      SOFT_MUTE   <= 1'b0;
      DEEMPH_MODE <= adsc_pkg::DEEMPH_OFF;
    end else if (sw_mode) begin
      SOFT_MUTE   <= play_w[adsc_pkg::SOFT_MUTE_BIT];
      DEEMPH_MODE <= deemph_reg;
    end else begin
      SOFT_MUTE   <= pin_mute;
      DEEMPH_MODE <= deemph_pin;
    end
  end

  // Mid-scale forcing; the modulator is disconnected while this is high.
  always_ff @(posedge CLK) begin
    if (hold) begin
      OUT_MID_SCALE <= 1'b1;
    end else if (state_q != adsc_pkg::ST_RUN) begin
      OUT_MID_SCALE <= 1'b1;
    end else if (!sw_mode) begin
      OUT_MID_SCALE <= 1'b0;
    end else if (play_w[adsc_pkg::FORCE_ZERO_BIT]) begin
      OUT_MID_SCALE <= 1'b1;
    end else begin
      OUT_MID_SCALE <= play_w[adsc_pkg::ZERO_DETECT_BIT] && zero_run_hit;
    end
  end

  // Input format selections.
  always_ff @(posedge CLK) begin
    if (hold) begin
      I2S_FORMAT  <= 1'b0;
      WORD_LEN_18 <= 1'b0;
      LR_POLARITY <= 1'b0;
    end else if (sw_mode) begin
      I2S_FORMAT  <= fmt_w[adsc_pkg::I2S_FORMAT_BIT];
      WORD_LEN_18 <= fmt_w[adsc_pkg::WORD_LENGTH_BIT];
      LR_POLARITY <= fmt_w[adsc_pkg::LR_POLARITY_BIT];
    end else begin
      I2S_FORMAT  <= 1'b0;
      WORD_LEN_18 <= 1'b0;
      LR_POLARITY <= 1'b0;
    end
  end

  // Channel currently carried by the left-right clock.
  always_ff @(posedge CLK) begin
    if (hold) begin
      CHAN_IS_LEFT <= 1'b0;
    end else if (sw_mode) begin
      CHAN_IS_LEFT <= pins_s.lr_clock ^ fmt_w[adsc_pkg::LR_POLARITY_BIT];
    end else begin
      CHAN_IS_LEFT <= pins_s.lr_clock;
    end
  end

  // Output routing.
  always_ff @(posedge CLK) begin
    if (hold) begin
      LEFT_ROUTE  <= adsc_pkg::ROUTE_LEFT;
      RIGHT_ROUTE <= adsc_pkg::ROUTE_RIGHT;
    end else if (sw_mode) begin
      LEFT_ROUTE  <= left_route_reg;
      RIGHT_ROUTE <= right_route_reg;
    end else begin
      LEFT_ROUTE  <= adsc_pkg::ROUTE_LEFT;
      RIGHT_ROUTE <= adsc_pkg::ROUTE_RIGHT;
    end
  end

  // Port ready for latching words.
  always_ff @(posedge CLK) begin
    if (hold) begin
      CTRL_READY <= 1'b0;
    end else begin
      CTRL_READY <= (state_q == adsc_pkg::ST_RUN) && sw_mode;
    end
  end

endmodule : adsc_ctrl_regs

// ### testbench/adsc_host_model.sv
/*
  Host controller model that drives the three-wire serial control port.
  Assumes the bench calls send_word from one process at a time.
*/
`timescale 1ns/1ps
module adsc_host_model (
  input  wire logic clk,
  output logic      sclk,
  output logic      latch,
  output logic      sdata
);
  initial begin
    sclk = 1'b0;
    latch = 1'b0;
    sdata = 1'b0;
  end

  // Shifts one word in; hold sets the length of each clock phase.
  task automatic send_word(input logic [1:0] sel, input logic [8:0] payload,
                           input int unsigned hold);
    logic [15:0] word;
    word = {5'h00, sel, payload};
    @(posedge clk);
    latch <= 1'b1;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk);
      sdata <= word[i];
      repeat (hold) @(posedge clk);
      sclk <= 1'b1;
      repeat (hold) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (hold) @(posedge clk);
    latch <= 1'b0;
    sdata <= ~word[0];
    repeat (8) @(posedge clk);
  endtask : send_word
endmodule : adsc_host_model

// ### testbench/adsc_ctrl_regs_checker.sv
/*
  Checker of the serial control register bank, watching only the top ports.
  Assumes one clock domain with a synchronous active-high reset; attached by bind.
*/
`timescale 1ns/1ps
module adsc_ctrl_regs_checker #(
  parameter int unsigned ZERO_RUN_BITS = 65536
) (
  input wire logic                   CLK,
  input wire logic                   RST,
  input wire logic                   MODE_SELECT,
  input wire logic                   EXTERNAL_RESET_PIN_N,
  input wire logic                   CONTROL_LATCH,
  input wire logic                   SERIAL_BIT_CLOCK,
  input wire logic                   LEFT_RIGHT_CLOCK,
  input wire logic                   AUDIO_DATA_IN,
  input wire logic [8:0]             LEFT_GAIN,
  input wire logic [8:0]             RIGHT_GAIN,
  input wire logic                   SOFT_MUTE,
  input wire adsc_pkg::adsc_deemph_t DEEMPH_MODE,
  input wire logic                   OUT_MID_SCALE,
  input wire logic                   I2S_FORMAT,
  input wire logic                   WORD_LEN_18,
  input wire logic                   LR_POLARITY,
  input wire logic                   CHAN_IS_LEFT,
  input wire adsc_pkg::adsc_route_t  LEFT_ROUTE,
  input wire adsc_pkg::adsc_route_t  RIGHT_ROUTE,
  input wire logic                   CTRL_READY
);
  logic [10:0] init_cnt_q;
  logic [3:0]  latch_age_q;
  logic [16:0] zrun_q;
  logic        bclk_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  always_ff @(posedge CLK) begin
    if (RST || !EXTERNAL_RESET_PIN_N) begin
      init_cnt_q <= 11'h000;
    end else if (init_cnt_q != 11'h7ff) begin
      init_cnt_q <= init_cnt_q + 11'h001;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || $fell(CONTROL_LATCH)) begin
      latch_age_q <= 4'h0;
    end else if (latch_age_q != 4'hf) begin
      latch_age_q <= latch_age_q + 4'h1;
    end
  end

  always_ff @(posedge CLK) begin
    bclk_q <= SERIAL_BIT_CLOCK;
    if (RST) begin
      zrun_q <= 17'h00000;
    end else if (SERIAL_BIT_CLOCK && !bclk_q) begin
      zrun_q <= AUDIO_DATA_IN ? 17'h00000 : zrun_q + {16'h0000, ~&zrun_q};
    end
  end

  sequence seq_pin_low;
    !EXTERNAL_RESET_PIN_N [*6];
  endsequence
  sequence seq_mode_low;
    !MODE_SELECT [*6];
  endsequence
  sequence seq_steady;
    (CTRL_READY && MODE_SELECT) [*3];
  endsequence

  a_gain_range: assert property (
    LEFT_GAIN != 9'h0ff && LEFT_GAIN <= 9'h100 && RIGHT_GAIN != 9'h0ff && RIGHT_GAIN <= 9'h100)
    else $error("gain outside the legal set");
  a_reset_mid: assert property (seq_pin_low |-> OUT_MID_SCALE)
    else $error("reset pin low without mid-scale");
  a_reset_ready: assert property (seq_pin_low |-> !CTRL_READY)
    else $error("ready while reset pin low");
  a_mode_ready: assert property (seq_mode_low |-> !CTRL_READY)
    else $error("ready while in pin mode");
  a_init_length: assert property ($rose(CTRL_READY) |-> init_cnt_q >= 11'h400)
    else $error("ready before initialisation ended");
  a_write_on_latch: assert property (seq_steady ##0 !$stable({LEFT_GAIN, RIGHT_GAIN,
    SOFT_MUTE, DEEMPH_MODE, I2S_FORMAT, WORD_LEN_18, LR_POLARITY, LEFT_ROUTE, RIGHT_ROUTE})
    |-> latch_age_q <= 4'h8)
    else $error("control output changed without a latch fall");
  a_zero_rise: assert property (seq_steady ##0 $rose(OUT_MID_SCALE)
    |-> latch_age_q <= 4'h8 || zrun_q >= ZERO_RUN_BITS - 1)
    else $error("mid-scale rose before the zero run ended");
  a_zero_fall: assert property (seq_steady ##0 $fell(OUT_MID_SCALE)
    |-> latch_age_q <= 4'h8 || zrun_q == 17'h00000)
    else $error("mid-scale fell without nonzero input");
  a_chan_polarity: assert property (
    ($stable({LEFT_RIGHT_CLOCK, LR_POLARITY}) && EXTERNAL_RESET_PIN_N) [*8]
    |-> CHAN_IS_LEFT == (LEFT_RIGHT_CLOCK ^ LR_POLARITY))
    else $error("channel flag does not follow the frame clock");
endmodule : adsc_ctrl_regs_checker

bind adsc_ctrl_regs adsc_ctrl_regs_checker #(.ZERO_RUN_BITS(ZERO_RUN_BITS)) u_checker (
  .CLK(CLK), .RST(RST), .MODE_SELECT(MODE_SELECT),
  .EXTERNAL_RESET_PIN_N(EXTERNAL_RESET_PIN_N), .CONTROL_LATCH(CONTROL_LATCH),
  .SERIAL_BIT_CLOCK(SERIAL_BIT_CLOCK), .LEFT_RIGHT_CLOCK(LEFT_RIGHT_CLOCK),
  .AUDIO_DATA_IN(AUDIO_DATA_IN), .LEFT_GAIN(LEFT_GAIN), .RIGHT_GAIN(RIGHT_GAIN),
  .SOFT_MUTE(SOFT_MUTE), .DEEMPH_MODE(DEEMPH_MODE), .OUT_MID_SCALE(OUT_MID_SCALE),
  .I2S_FORMAT(I2S_FORMAT), .WORD_LEN_18(WORD_LEN_18), .LR_POLARITY(LR_POLARITY),
  .CHAN_IS_LEFT(CHAN_IS_LEFT), .LEFT_ROUTE(LEFT_ROUTE), .RIGHT_ROUTE(RIGHT_ROUTE),
  .CTRL_READY(CTRL_READY));

// ### testbench/adsc_ctrl_regs_bench.sv
/*
  Self-checking bench of the serial control register bank with a host model.
  Assumes the host model and the checker are compiled before it.
*/
`timescale 1ns/1ps
module adsc_ctrl_regs_bench;
  localparam int unsigned ZRUN = 16;
  logic                   clk = 1'b0;
  logic                   bclk = 1'b0;
  logic                   rst, mode, pin_n, lrclk, adata, sclk, latch, sdata;
  logic                   soft_mute, mid, i2s, wl18, lr_polarity, chan, ready, zmid;
  logic [8:0]             left_gain, right_gain, r2, r3;
  logic [7:0]             lcode, rcode, lact, ract, c;
  logic [7:0]             corners [4] = '{8'h00, 8'h01, 8'hfe, 8'hff};
  adsc_pkg::adsc_deemph_t deemph;
  adsc_pkg::adsc_route_t  left_route, right_route;
  int                     error_cnt = 0;
  int                     compares = 0;
  int                     n;

  adsc_ctrl_regs #(.ZERO_RUN_BITS(ZRUN)) u_dut (
    .CLK(clk), .RST(rst), .MODE_SELECT(mode), .EXTERNAL_RESET_PIN_N(pin_n),
    .SERIAL_CONTROL_CLOCK(sclk), .CONTROL_LATCH(latch), .CONTROL_SERIAL_IN(sdata),
    .SERIAL_BIT_CLOCK(bclk), .LEFT_RIGHT_CLOCK(lrclk), .AUDIO_DATA_IN(adata),
    .LEFT_GAIN(left_gain), .RIGHT_GAIN(right_gain), .SOFT_MUTE(soft_mute),
    .DEEMPH_MODE(deemph), .OUT_MID_SCALE(mid), .I2S_FORMAT(i2s), .WORD_LEN_18(wl18),
    .LR_POLARITY(lr_polarity), .CHAN_IS_LEFT(chan), .LEFT_ROUTE(left_route),
    .RIGHT_ROUTE(right_route), .CTRL_READY(ready));
  adsc_host_model u_host (.clk(clk), .sclk(sclk), .latch(latch), .sdata(sdata));

  always #2.5 clk = ~clk;
  always #40 bclk = ~bclk;

  function automatic logic [8:0] gain_of(input logic [7:0] code);
    return (code == 8'hff) ? adsc_pkg::GAIN_UNITY : {1'b0, code};
  endfunction : gain_of

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic check_all(input logic init);
    check("left_gain", left_gain, gain_of(lact));
    check("right_gain", right_gain, gain_of(r3[3] ? lact : ract));
    check("soft_mute", soft_mute, r2[0]);
    check("deemph", deemph, r2[2:1]);
    check("mid_scale", mid, init | r2[3] | (r2[4] & zmid));
    check("format", {i2s, lr_polarity, wl18}, {r3[0], r3[1], r3[2]});
    check("routes", {left_route, right_route}, {r3[4], r3[5], r3[6], r3[7]});
    check("chan", chan, init ? 1'b0 : lrclk ^ r3[1]);
    check("ready", ready, !init);
  endtask : check_all

  task automatic model_reset();
    lcode = adsc_pkg::LEFT_VOLUME_RESET[7:0];
    rcode = adsc_pkg::RIGHT_VOLUME_RESET[7:0];
    lact = 8'hff;
    ract = 8'hff;
    r2 = adsc_pkg::PLAYBACK_CTRL_RESET[8:0];
    r3 = adsc_pkg::FORMAT_CTRL_RESET[8:0];
    zmid = 1'b0;
  endtask : model_reset

  task automatic wr(input logic [1:0] sel, input logic [8:0] payload);
    @(posedge clk);
    lrclk <= 1'($urandom);
    u_host.send_word(sel, payload, 4 + 2 * ($urandom % 3));
    case (sel)
      2'd0: begin
        lcode = payload[7:0];
        if (payload[8]) lact = lcode;
      end
      2'd1: begin
        rcode = payload[7:0];
        if (payload[8]) ract = rcode;
      end
      2'd2: r2 = payload;
      default: r3 = payload;
    endcase
    repeat (8) @(posedge clk);
    #1;
    check_all(1'b0);
  endtask : wr

  task automatic wait_ready();
    n = 0;
    while (ready !== 1'b1 && n < 1200) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("init_len", 16'(n >= 1024 && n <= 1040), 16'h0001);
  endtask : wait_ready

  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #300000;
    error_cnt++;
    $display("Error watchdog expected %h seen %h", 1'b1, 1'b0);
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    mode = 1'b1;
    pin_n = 1'b1;
    lrclk = 1'b0;
    adata = 1'b1;
    n = $urandom(99);
    model_reset();
    repeat (12) @(posedge clk);
    #1;
    check_all(1'b1);
    @(posedge clk);
    rst <= 1'b0;
    fork
      u_host.send_word(2'd2, 9'h001, 4);
    join_none
    wait_ready();
    check_all(1'b0);
    $display("Done reset and init");
    for (int i = 0; i < 12; i++) begin
      c = (i < 4) ? corners[i] : 8'($urandom);
      wr(2'(i % 2), {1'b0, 8'($urandom)});
      wr(2'(i % 2), {1'b1, c});
    end
    $display("Done volume");
    for (int i = 0; i < 32; i++) wr(2'd2, 9'(i));
    for (int i = 0; i < 16; i++) wr(2'd3, {1'b0, 4'(i), 4'($urandom)});
    $display("Done control words");
    wr(2'd2, 9'h010);
    @(posedge clk);
    adata <= 1'b0;
    repeat ((ZRUN / 2 + 2) * 16) @(posedge clk);
    #1;
    check_all(1'b0);
    repeat (ZRUN * 16) @(posedge clk);
    zmid = 1'b1;
    #1;
    check_all(1'b0);
    @(posedge clk);
    adata <= 1'b1;
    repeat (48) @(posedge clk);
    zmid = 1'b0;
    #1;
    check_all(1'b0);
    wr(2'd2, 9'h000);
    @(posedge clk);
    adata <= 1'b0;
    repeat (2 * ZRUN * 16) @(posedge clk);
    zmid = 1'b1;
    #1;
    check_all(1'b0);
    wr(2'd2, 9'h008);
    @(posedge clk);
    adata <= 1'b1;
    zmid = 1'b0;
    wr(2'd2, 9'h000);
    $display("Done zero detect");
    @(posedge clk);
    mode <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    check("ready_mode", ready, 16'h0000);
    check("pin_mute", soft_mute, !latch);
    check("pin_deemph", deemph, {sclk, sdata});
    check("pin_gain", left_gain, adsc_pkg::GAIN_UNITY);
    u_host.send_word(2'd2, 9'h001, 4);
    mode <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check_all(1'b0);
    $display("Done pin mode");
    @(posedge clk);
    pin_n <= 1'b0;
    lrclk <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    model_reset();
    check_all(1'b1);
    @(posedge clk);
    pin_n <= 1'b1;
    wait_ready();
    check_all(1'b0);
    $display("Done external reset");
    tally_and_finish();
  end
endmodule : adsc_ctrl_regs_bench
